// ==== rtl/ctsc_channel.sv ====
// one capture channel: trigger/sync control register, capture timer, apb slave
`timescale 1ns/1ps
`include "ctsc_params.svh"

module ctsc_channel #(
  parameter int NUM_SRC = 32,
  parameter int TMR_W = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger and sync sources from other modules, asynchronous
  input wire logic [NUM_SRC-1:0] src_in,
  // pair partner cascade bit, same clock
  input wire logic partner_cascade,
  // status towards the system
  output logic cascade_out,
  output logic cascaded,
  output logic trig_flag,
  output logic [TMR_W-1:0] timer_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ctsc_pkg::ctsc_state_t s_q;
  ctsc_pkg::ctsc_state_t s_d;
  logic src_raw;
  logic src_edge;
  logic wr_en;
  logic rd_en;
  logic [15:0] ctrl2_rd;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction : hit

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // source 0 means no source; the mux reads a synchronised bit only
  assign src_raw = (s_q.src_sel == 5'h00) ? 1'b0 : s_q.src_sync[s_q.src_sel];
  assign src_edge = src_raw & ~s_q.src_prev;
  assign wr_en = psel & penable & pwrite & ~s_q.pready;
  assign rd_en = psel & ~penable & ~pwrite;

  always_comb
  begin
    ctrl2_rd = 16'h0000;
    ctrl2_rd[`CTSC_BIT_CASCADE] = s_q.cascade;
    ctrl2_rd[`CTSC_BIT_TRIG_MODE] = s_q.trig_mode;
    ctrl2_rd[`CTSC_BIT_TRIG_FLAG] = s_q.trig_flag;
    ctrl2_rd[`CTSC_SEL_MSB:0] = s_q.src_sel;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // every source pin passes two flops before the selector looks at it
    s_d.src_meta = 32'(src_in);
    s_d.src_sync = s_q.src_meta;
    s_d.src_prev = src_raw;
    s_d.cascaded = s_q.cascade & partner_cascade;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;

    // timer behaviour
    if (s_q.trig_mode)
    begin
      if (s_q.trig_flag)
        s_d.timer = s_q.timer + 16'h0001;
      else
        s_d.timer = 16'h0000;
    end
    else
    begin
      s_d.trig_flag = 1'b1;
      if (src_edge)
        s_d.timer = 16'h0000;
      else
        s_d.timer = s_q.timer + 16'h0001;
    end

    // register write
    if (wr_en)
    begin
      s_d.pready = 1'b1;
      if (hit(paddr, `CTSC_ADDR_CTRL2))
      begin
        s_d.cascade = pwdata[`CTSC_BIT_CASCADE];
        s_d.trig_mode = pwdata[`CTSC_BIT_TRIG_MODE];
        s_d.trig_flag = pwdata[`CTSC_BIT_TRIG_FLAG];
        s_d.src_sel = pwdata[`CTSC_SEL_MSB:0];
        if (!pwdata[`CTSC_BIT_TRIG_FLAG] && pwdata[`CTSC_BIT_TRIG_MODE])
          s_d.timer = 16'h0000;
      end
      else if (hit(paddr, `CTSC_ADDR_IRQ_STAT))
        s_d.irq_stat = s_q.irq_stat & ~pwdata[1:0];
      else if (hit(paddr, `CTSC_ADDR_IRQ_MASK))
        s_d.irq_mask = pwdata[1:0];
      else if (!hit(paddr, `CTSC_ADDR_TIMER))
        s_d.pslverr = 1'b1;
    end
    else if (psel & penable & ~s_q.pready)
      s_d.pready = 1'b1;

    // register read, data captured in setup so it stands in access
    if (rd_en)
    begin
      if (hit(paddr, `CTSC_ADDR_CTRL2))
        s_d.prdata = {16'h0000, ctrl2_rd};
      else if (hit(paddr, `CTSC_ADDR_TIMER))
        s_d.prdata = {16'h0000, s_q.timer};
      else if (hit(paddr, `CTSC_ADDR_IRQ_STAT))
        s_d.prdata = {30'h0, s_q.irq_stat};
      else if (hit(paddr, `CTSC_ADDR_IRQ_MASK))
        s_d.prdata = {30'h0, s_q.irq_mask};
    end
    else if (psel & penable & ~pwrite & ~s_q.pready)
    begin
      s_d.prdata = s_q.prdata;
      if (!(hit(paddr, `CTSC_ADDR_CTRL2) || hit(paddr, `CTSC_ADDR_TIMER)
          || hit(paddr, `CTSC_ADDR_IRQ_STAT) || hit(paddr, `CTSC_ADDR_IRQ_MASK)))
        s_d.pslverr = 1'b1;
    end

    // in trigger mode, hardware set of the flag wins over a software clear in the same cycle
    if (s_q.trig_mode && src_edge)
      s_d.trig_flag = 1'b1;

    // interrupt events; set wins over write-one-to-clear
    if (s_q.trig_mode && src_edge && !s_q.trig_flag)
      s_d.irq_stat[`CTSC_IRQ_TRIG] = 1'b1;
    if (s_q.timer == 16'hFFFF && s_d.timer == 16'h0000)
      s_d.irq_stat[`CTSC_IRQ_WRAP] = 1'b1;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.src_sel <= 5'h0D;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign cascade_out = s_q.cascade;
  assign cascaded = s_q.cascaded;
  assign trig_flag = s_q.trig_flag;
  assign timer_out = s_q.timer;
  assign irq = s_q.irq;

endmodule : ctsc_channel

// ==== rtl/ctsc_params.svh ====
// constants for the capture trigger/sync control block
`ifndef CTSC_PARAMS_SVH
`define CTSC_PARAMS_SVH
// register byte addresses
`define CTSC_ADDR_CTRL2 12'h000
`define CTSC_ADDR_TIMER 12'h004
`define CTSC_ADDR_IRQ_STAT 12'h008
`define CTSC_ADDR_IRQ_MASK 12'h00C
// control register field positions
`define CTSC_BIT_CASCADE 8
`define CTSC_BIT_TRIG_MODE 7
`define CTSC_BIT_TRIG_FLAG 6
`define CTSC_SEL_MSB 4
// reset value of the control register: source select 5'b01101
`define CTSC_CTRL2_RESET 16'h000D
// readable bits: 8..6 and 4..0
`define CTSC_CTRL2_MASK 16'h01DF
// interrupt status bits
`define CTSC_IRQ_TRIG 0
`define CTSC_IRQ_WRAP 1
`endif

// ==== rtl/ctsc_pkg.sv ====
// types for the capture trigger/sync control block
package ctsc_pkg;

  typedef enum logic [1:0] {
    CTSC_SYNC_MODE,
    CTSC_TRIG_IDLE,
    CTSC_TRIG_RUN
  } ctsc_mode_t;

  typedef struct packed {
    logic cascade;
    logic trig_mode;
    logic trig_flag;
    logic [4:0] src_sel;
    logic [15:0] timer;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] src_meta;
    logic [31:0] src_sync;
    logic src_prev;
    logic cascaded;
  } ctsc_state_t;

endpackage : ctsc_pkg

// ==== test/ctsc_channel_monitor.sv ====
// port checker for the capture channel
`timescale 1ns/1ps
module ctsc_channel_monitor (
  // bus
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // channel
  input wire logic partner_cascade,
  input wire logic cascade_out,
  input wire logic cascaded,
  input wire logic trig_flag,
  input wire logic [15:0] timer_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_ran;
    trig_flag ##1 trig_flag;
  endsequence
  a_cascade_join: assert property (cascaded == $past(cascade_out & partner_cascade))
    else $error("cascade mismatch");
  a_held_clear: assert property (timer_out != 16'h0 |-> trig_flag)
    else $error("timer runs untriggered");
  a_run_count: assert property (s_ran |-> timer_out == 16'h0 ||
    timer_out == $past(timer_out) + 16'h1) else $error("timer not counting");
  a_reset_clear: assert property ($past(reset) |-> !trig_flag && timer_out == 16'h0)
    else $error("not clear after reset");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_read: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : ctsc_channel_monitor

bind ctsc_channel ctsc_channel_monitor u_mon (.sys_clk(sys_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .partner_cascade(partner_cascade), .cascade_out(cascade_out),
  .cascaded(cascaded), .trig_flag(trig_flag), .timer_out(timer_out));

// ==== test/ctsc_src_model.sv ====
// model of the trigger and sync sources of other modules
`timescale 1ns/1ps
module ctsc_src_model (
  // from the bench
  input wire logic fire,
  input wire logic [4:0] pick,
  // towards the channel
  output logic [31:0] src_in
);
  // sources are levels, not tied to our clock edge
  assign src_in = {32{fire}} & (32'h1 << pick);
endmodule : ctsc_src_model

// ==== test/test_capture_timer_trigger_sync_control.sv ====
// self-checking bench for the capture channel
`timescale 1ns/1ps
`include "ctsc_params.svh"
module test_capture_timer_trigger_sync_control;
  logic sys_clk, pready, pslverr, cascade_out, cascaded, trig_flag, irq, pslv;
  logic reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, fire = 1'h0;
  logic partner_cascade = 1'h0;
  logic [4:0] pick = 5'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, src_in, rd, t0;
  logic [15:0] timer_out;
  int err_count = 0, check_count = 0;
  ctsc_channel u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_in(src_in), .partner_cascade(partner_cascade),
    .cascade_out(cascade_out), .cascaded(cascaded), .trig_flag(trig_flag),
    .timer_out(timer_out), .irq(irq));
  ctsc_src_model u_src (.fire(fire), .pick(pick), .src_in(src_in));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1 && ++n < 20);
    chk("pready", 1, pready);
    rd = prdata;
    pslv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  task complete_run;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    #30000;
    err_count++;
    complete_run;
  end
  // source pulse; the edge needs two cycles through the synchroniser
  task pulse;
    pick <= 5'h03;
    fire <= 1'h1;
    repeat (6) @(posedge sys_clk);
    fire <= 1'h0;
  endtask : pulse
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'h0;
    xfer(0, `CTSC_ADDR_CTRL2, 0);
    chk("ctrl reset", 32'h0000004D, rd);
    partner_cascade <= 1'h1;
    xfer(1, `CTSC_ADDR_CTRL2, 32'hFFFFFFFF);
    xfer(0, `CTSC_ADDR_CTRL2, 0);
    chk("ctrl bits", 32'h000001DF, rd);
    chk("cascaded", 1, cascaded);
    chk("cascade out", 1, cascade_out);
    xfer(1, `CTSC_ADDR_CTRL2, 32'h83);
    xfer(0, `CTSC_ADDR_TIMER, 0);
    chk("held timer", 0, rd);
    xfer(1, `CTSC_ADDR_IRQ_MASK, 1);
    pulse();
    chk("flag", 1, trig_flag);
    chk("irq", 1, irq);
    xfer(0, `CTSC_ADDR_TIMER, 0);
    t0 = rd;
    xfer(0, `CTSC_ADDR_TIMER, 0);
    chk("counting", 1, rd > t0);
    xfer(1, `CTSC_ADDR_CTRL2, 32'h83);
    xfer(1, `CTSC_ADDR_IRQ_STAT, 1);
    xfer(0, `CTSC_ADDR_TIMER, 0);
    chk("cleared", 0, {rd[15:0], trig_flag, irq});
    xfer(0, 12'h010, 0);
    chk("unmapped", 1, pslv);
    xfer(1, `CTSC_ADDR_CTRL2, 32'h03);
    pulse();
    xfer(0, `CTSC_ADDR_CTRL2, 0);
    chk("sync flag", 32'h43, rd);
    chk("sync zeroed", 1, timer_out < 16'h0008);
    complete_run;
  end
endmodule : test_capture_timer_trigger_sync_control
